// file: rtl/drive_regs_pkg.sv
// Register map, field layout and code constants of the drive fieldbus register bank
package drive_regs_pkg;

  // Holding register numbers of the fixed map
  localparam logic [15:0] REG_CONTROL      = 16'h0001;
  localparam logic [15:0] REG_SETPOINT     = 16'h0002;
  localparam logic [15:0] REG_RAMP         = 16'h0004;
  localparam logic [15:0] REG_STATUS       = 16'h0006;
  localparam logic [15:0] REG_OUT_FREQ     = 16'h0007;
  localparam logic [15:0] REG_OUT_CURRENT  = 16'h0008;
  localparam logic [15:0] REG_INPUT_PINS   = 16'h000B;
  localparam logic [15:0] REG_ANALOG_ONE   = 16'h0014;
  localparam logic [15:0] REG_ANALOG_TWO   = 16'h0015;
  localparam logic [15:0] REG_SPEED_REF    = 16'h0016;
  localparam logic [15:0] REG_BUS_VOLTAGE  = 16'h0017;
  localparam logic [15:0] REG_HEATSINK     = 16'h0018;

  // Highest register that the multiple write may target
  localparam logic [15:0] MULTI_LAST_REG   = 16'h0004;

  // User parameters sit at a fixed base above their number
  localparam logic [15:0] PARAM_BASE       = 16'h0080;
  localparam logic [15:0] PARAM_FIRST      = 16'h0004;
  localparam logic [15:0] PARAM_LAST       = 16'h003C;
  localparam int          PARAM_COUNT      = 57;
  localparam int          PARAM_IDX_W      = 6;

  // Control word bit positions
  localparam int          CTL_RUN_BIT      = 0;
  localparam int          CTL_DECEL_BIT    = 1;
  localparam int          CTL_RESET_BIT    = 2;
  localparam int          CTL_COAST_BIT    = 3;
  localparam int          CTL_BITS         = 4;

  // Status word field positions
  localparam int          STAT_ERR_LSB     = 0;
  localparam int          STAT_STATE_LSB   = 8;

  // Drive state codes in the status high byte
  localparam logic [1:0]  STATE_STOPPED    = 2'h0;
  localparam logic [1:0]  STATE_RUNNING    = 2'h1;
  localparam logic [1:0]  STATE_TRIPPED    = 2'h2;

  // Reset values of the writable registers
  localparam logic [3:0]  CTL_RESET_VAL    = 4'h0;
  localparam logic [15:0] SETPOINT_RESET   = 16'h0000;
  localparam logic [15:0] RAMP_RESET       = 16'h0000;
  localparam logic [15:0] PARAM_RESET      = 16'h0000;

  // Function codes served by the bank
  localparam logic [7:0]  FUNC_READ        = 8'h03;
  localparam logic [7:0]  FUNC_WRITE_ONE   = 8'h06;
  localparam logic [7:0]  FUNC_WRITE_MANY  = 8'h10;

  // Exception codes of the answer
  localparam logic [7:0]  EXC_NONE         = 8'h00;
  localparam logic [7:0]  EXC_FUNC         = 8'h01;
  localparam logic [7:0]  EXC_ADDR         = 8'h02;

endpackage

// file: rtl/param_store.sv
// Flip-flop store of the user-configurable drive parameters
`timescale 1ns/1ns
module param_store
  import drive_regs_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   wr_en_i,
  input  wire logic [PARAM_IDX_W-1:0] wr_idx_i,
  input  wire logic [15:0]            wr_data_i,
  input  wire logic [PARAM_IDX_W-1:0] rd_idx_i,
  output logic      [15:0]            rd_data_o
);

  // One word per parameter, index 0 is the first user parameter
  logic [15:0] param_mem [PARAM_COUNT];

  // Write port; all words clear on reset so reads are never unknown
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        param_mem[i] <= PARAM_RESET;
      end
    end else if (wr_en_i) begin
      param_mem[wr_idx_i] <= wr_data_i;
    end
  end

  // Read port; indices past the last parameter read as the reset value
  always_comb begin
    rd_data_o = PARAM_RESET;
    if (int'(rd_idx_i) < PARAM_COUNT) begin
      rd_data_o = param_mem[rd_idx_i];
    end
  end

endmodule

// file: rtl/drive_fieldbus_register_map.sv
// Fieldbus holding-register bank of a motor drive
//
// Summary of operation
// - Control bit 0: clear stops, set enables run
// - Control bit 1 picks deceleration ramp one/two
// - Control bit 2 set requests fault reset
// - Control bit 3 set requests coast stop
// - Setpoint register counts tenths of a hertz
// - Ramp register counts hundredths of a second
// - Status low byte holds drive error code
// - Status high byte: stopped, running, tripped
// - Output frequency reads in tenths of hertz
// - Output current reads in tenths of ampere
// - Four digital inputs, input one lowest bit
// - Analog inputs read in tenths of percent
// - Speed reference reads in tenths of hertz
// - Bus volts and heatsink degrees read whole
// - Parameters 4..60 at register 128 plus number
// - Multiple write only for registers one to four
// - Link characters: start, eight data, stop
`timescale 1ns/1ns
module drive_fieldbus_register_map
  import drive_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Decoded request, one register per request
  input  wire logic        req_valid_i,
  input  wire logic [7:0]  req_func_i,
  input  wire logic [15:0] req_reg_i,
  input  wire logic [15:0] req_data_i,
  // Answer, one cycle after each request
  output logic             rsp_valid_o,
  output logic             rsp_exc_o,
  output logic      [15:0] rsp_data_o,
  // Commands to the motor control
  output logic             run_enable_o,
  output logic             decel_sel_o,
  output logic             fault_reset_o,
  output logic             coast_stop_o,
  output logic      [15:0] speed_setpoint_o,
  output logic      [15:0] ramp_time_o,
  output logic             param_wr_o,
  output logic      [5:0]  param_num_o,
  output logic      [15:0] param_data_o,
  // Live state of the drive
  input  wire logic [7:0]  error_code_i,
  input  wire logic [1:0]  drive_state_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [15:0] out_current_i,
  input  wire logic [3:0]  din_pins_i,
  input  wire logic [15:0] analog_one_display_param_i,
  input  wire logic [15:0] analog_two_display_param_i,
  input  wire logic [15:0] speed_ref_display_param_i,
  input  wire logic [15:0] bus_voltage_display_param_i,
  input  wire logic [15:0] temperature_display_param_i
);

  // True for a register number inside the user parameter window
  function automatic logic is_param(input logic [15:0] r);
    is_param = (r >= PARAM_BASE + PARAM_FIRST) && (r <= PARAM_BASE + PARAM_LAST);
  endfunction

  // True for a register the master may write
  function automatic logic is_writable(input logic [15:0] r);
    is_writable = (r == REG_CONTROL) || (r == REG_SETPOINT) || (r == REG_RAMP)
                  || is_param(r);
  endfunction

  // True for a register the master may read
  function automatic logic is_readable(input logic [15:0] r);
    case (r)
      REG_CONTROL, REG_SETPOINT, REG_RAMP, REG_STATUS, REG_OUT_FREQ,
      REG_OUT_CURRENT, REG_INPUT_PINS, REG_ANALOG_ONE, REG_ANALOG_TWO,
      REG_SPEED_REF, REG_BUS_VOLTAGE, REG_HEATSINK: is_readable = 1'b1;
      default: is_readable = is_param(r);
    endcase
  endfunction

  // Parameter store index from a register number
  function automatic logic [PARAM_IDX_W-1:0] param_idx(input logic [15:0] r);
    logic [15:0] d;
    d = r - (PARAM_BASE + PARAM_FIRST);
    param_idx = d[PARAM_IDX_W-1:0];
  endfunction

  logic [7:0]  exc_code;      // Exception of the present request
  logic        req_ok;        // Legal request taken this cycle
  logic        wr_ok;         // Legal write taken this cycle
  logic        ctl_hit;       // Write to the control word
  logic        sp_hit;        // Write to the speed setpoint
  logic        ramp_hit;      // Write to the ramp time
  logic        par_hit;       // Write to a user parameter
  logic [3:0]  ctl_reg;       // Stored control bits
  logic [3:0]  din_meta_reg;  // First synchroniser stage of the pins
  logic [3:0]  din_sync_reg;  // Pins safe to read
  logic [15:0] par_rd_data;   // Addressed parameter word
  logic [15:0] rd_next;       // Read data before the answer flop

  // Classify the request; anything illegal gets an exception code
  always_comb begin
    exc_code = EXC_NONE;
    case (req_func_i)
      FUNC_READ: begin
        if (!is_readable(req_reg_i)) begin
          exc_code = EXC_ADDR;
        end
      end
      FUNC_WRITE_ONE: begin
        if (!is_writable(req_reg_i)) begin
          exc_code = EXC_ADDR;
        end
      end
      FUNC_WRITE_MANY: begin
        // Multiple writes reach only the command registers
        if (!is_writable(req_reg_i) || req_reg_i > MULTI_LAST_REG) begin
          exc_code = EXC_ADDR;
        end
      end
      default: begin
        exc_code = EXC_FUNC;
      end
    endcase
  end

  // Write strobes gated by legality so a refused write changes nothing
  assign req_ok   = req_valid_i && (exc_code == EXC_NONE);
  assign wr_ok    = req_ok && (req_func_i != FUNC_READ);
  assign ctl_hit  = wr_ok && (req_reg_i == REG_CONTROL);
  assign sp_hit   = wr_ok && (req_reg_i == REG_SETPOINT);
  assign ramp_hit = wr_ok && (req_reg_i == REG_RAMP);
  assign par_hit  = wr_ok && is_param(req_reg_i);

  // Pins come from outside the clock domain: two flops before use
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      din_meta_reg <= 4'h0;
      din_sync_reg <= 4'h0;
    end else begin
      din_meta_reg <= din_pins_i;
      din_sync_reg <= din_meta_reg;
    end
  end

  // Control word; upper bits are not stored and read as zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctl_reg <= CTL_RESET_VAL;
    end else if (ctl_hit) begin
      ctl_reg <= req_data_i[CTL_BITS-1:0];
    end
  end

  // Command levels straight from the stored bits
  assign run_enable_o = ctl_reg[CTL_RUN_BIT];
  assign decel_sel_o  = ctl_reg[CTL_DECEL_BIT];
  assign coast_stop_o = ctl_reg[CTL_COAST_BIT];

  // Fault reset is an edge request: a pulse per write with the bit set,
  // so a bit left high does not hold the drive in reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fault_reset_o <= 1'b0;
    end else begin
      fault_reset_o <= ctl_hit && req_data_i[CTL_RESET_BIT];
    end
  end

  // Setpoint in tenths of a hertz, passed on unscaled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      speed_setpoint_o <= SETPOINT_RESET;
    end else if (sp_hit) begin
      speed_setpoint_o <= req_data_i;
    end
  end

  // Ramp time in hundredths of a second, passed on unscaled
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ramp_time_o <= RAMP_RESET;
    end else if (ramp_hit) begin
      ramp_time_o <= req_data_i;
    end
  end

  // User parameter words; number is register minus the base
  param_store u_param_store (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wr_en_i   (par_hit),
    .wr_idx_i  (param_idx(req_reg_i)),
    .wr_data_i (req_data_i),
    .rd_idx_i  (param_idx(req_reg_i)),
    .rd_data_o (par_rd_data)
  );

  // Tell the motor control which parameter changed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      param_wr_o   <= 1'b0;
      param_num_o  <= 6'h00;
      param_data_o <= PARAM_RESET;
    end else begin
      param_wr_o <= par_hit;
      if (par_hit) begin
        param_num_o  <= 6'(req_reg_i - PARAM_BASE);
        param_data_o <= req_data_i;
      end
    end
  end

  // Read multiplexer; live values are sampled in the request cycle
  always_comb begin
    rd_next = 16'h0000;
    case (req_reg_i)
      REG_CONTROL:     rd_next = {12'h000, ctl_reg};
      REG_SETPOINT:    rd_next = speed_setpoint_o;
      REG_RAMP:        rd_next = ramp_time_o;
      REG_STATUS: begin
        rd_next[STAT_ERR_LSB +: 8]   = error_code_i;
        rd_next[STAT_STATE_LSB +: 2] = drive_state_i;
      end
      REG_OUT_FREQ:    rd_next = out_freq_i;
      REG_OUT_CURRENT: rd_next = out_current_i;
      REG_INPUT_PINS:  rd_next = {12'h000, din_sync_reg};
      REG_ANALOG_ONE:  rd_next = analog_one_display_param_i;
      REG_ANALOG_TWO:  rd_next = analog_two_display_param_i;
      REG_SPEED_REF:   rd_next = speed_ref_display_param_i;
      REG_BUS_VOLTAGE: rd_next = bus_voltage_display_param_i;
      REG_HEATSINK:    rd_next = temperature_display_param_i;
      default: begin
        if (is_param(req_reg_i)) begin
          rd_next = par_rd_data;
        end
      end
    endcase
  end

  // Answer: read data, write echo, or exception code in the low byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_exc_o   <= 1'b0;
      rsp_data_o  <= 16'h0000;
    end else begin
      rsp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        rsp_exc_o <= (exc_code != EXC_NONE);
        if (exc_code != EXC_NONE) begin
          rsp_data_o <= {8'h00, exc_code};
        end else if (req_func_i == FUNC_READ) begin
          // Whole 16-bit words; the link framer splits each into 8-bit characters
          rsp_data_o <= rd_next;
        end else begin
          rsp_data_o <= req_data_i;
        end
      end
    end
  end

  // Checks on the command side

  run_enable_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctl_hit |=> run_enable_o == $past(req_data_i[CTL_RUN_BIT]) [*1] ##1
      (run_enable_o == $past(run_enable_o) || $past(ctl_hit)))
    else $error("run enable does not follow control bit 0");

  decel_select_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctl_hit |=> decel_sel_o == $past(req_data_i[CTL_DECEL_BIT]))
    else $error("deceleration select does not follow control bit 1");

  fault_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    fault_reset_o |-> $past(ctl_hit) && $past(req_data_i[CTL_RESET_BIT])
      ##1 (!fault_reset_o || $past(ctl_hit)))
    else $error("fault reset pulse without a request");

  coast_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ctl_hit |=> coast_stop_o == $past(req_data_i[CTL_COAST_BIT]))
    else $error("coast stop does not follow control bit 3");

  setpoint_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sp_hit |=> speed_setpoint_o == $past(req_data_i))
    else $error("speed setpoint not stored");

  ramp_store_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ramp_hit |=> ramp_time_o == $past(req_data_i))
    else $error("ramp time not stored");

  // Checks on the answer side and on parameter write reporting

  status_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_func_i == FUNC_READ && req_reg_i == REG_STATUS
      |=> rsp_valid_o && !rsp_exc_o
      && rsp_data_o == {6'h00, $past(drive_state_i), $past(error_code_i)})
    else $error("status word wrong");

  freq_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_func_i == FUNC_READ && req_reg_i == REG_OUT_FREQ
      |=> rsp_data_o == $past(out_freq_i))
    else $error("output frequency read wrong");

  pins_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_func_i == FUNC_READ && req_reg_i == REG_INPUT_PINS
      |=> rsp_data_o == {12'h000, $past(din_pins_i, 3)})
    else $error("digital input read wrong");

  param_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    par_hit |=> param_wr_o && param_data_o == $past(req_data_i)
      && param_num_o == 6'($past(req_reg_i) - PARAM_BASE))
    else $error("parameter write not reported");

  multi_reject_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_func_i == FUNC_WRITE_MANY && req_reg_i > MULTI_LAST_REG
      |=> rsp_exc_o && rsp_data_o == {8'h00, EXC_ADDR} && !param_wr_o)
    else $error("multiple write beyond register four accepted");

  ro_reject_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    req_valid_i && req_func_i != FUNC_READ && !is_writable(req_reg_i)
      |=> rsp_exc_o && $stable(speed_setpoint_o) && $stable(ramp_time_o)
      && $stable(ctl_reg))
    else $error("refused write changed stored state");

endmodule

// file: sim/fieldbus_master.sv
// Fieldbus master model that issues one-register requests to the bank
`timescale 1ns/1ns
module fieldbus_master
  import drive_regs_pkg::*;
(
  input  wire logic        clk_i,
  output logic             req_valid_o,
  output logic [7:0]       req_func_o,
  output logic [15:0]      req_reg_o,
  output logic [15:0]      req_data_o,
  input  wire logic        rsp_valid_i,
  input  wire logic        rsp_exc_i,
  input  wire logic [15:0] rsp_data_i
);
  // Idle link: no request, qualifiers at a known pattern
  initial begin
    req_valid_o = 1'b0;
    req_func_o  = 8'h00;
    req_reg_o   = 16'h0000;
    req_data_o  = 16'h0000;
  end

  // One request per call; the answer is read at the falling edge that follows the taking edge
  task automatic xfer(input logic [7:0] func, input logic [15:0] regn,
                      input logic [15:0] data, output logic got, output logic exc,
                      output logic [15:0] rdata);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_func_o  = func;
    req_reg_o   = regn;
    req_data_o  = data;
    @(negedge clk_i);
    got   = rsp_valid_i;
    exc   = rsp_exc_i;
    rdata = rsp_data_i;
    req_valid_o = 1'b0;
    // Released qualifiers flip so a stale value never passes for a fresh one
    req_func_o  = ~req_func_o;
    req_reg_o   = ~req_reg_o;
    req_data_o  = ~req_data_o;
  endtask
endmodule

// file: sim/tb_drive_fieldbus_register_map.sv
// Self-checking bench of the drive fieldbus register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_drive_fieldbus_register_map
  import drive_regs_pkg::*;
();
  logic        clk_i = 1'b0;                   // 10 MHz bench clock
  logic        rst_n_i;                        // Synchronous reset, active low
  logic        req_valid_i;
  logic [7:0]  req_func_i;
  logic [15:0] req_reg_i, req_data_i;
  logic        rsp_valid_o, rsp_exc_o;
  logic [15:0] rsp_data_o;
  logic        run_enable_o, decel_sel_o, fault_reset_o, coast_stop_o, param_wr_o;
  logic [15:0] speed_setpoint_o, ramp_time_o, param_data_o;
  logic [5:0]  param_num_o;
  logic [7:0]  error_code_i;                   // Live drive state, driven by the bench
  logic [1:0]  drive_state_i;
  logic [15:0] out_freq_i, out_current_i;
  logic [3:0]  din_pins_i;
  logic [15:0] analog_one_display_param_i, analog_two_display_param_i;
  logic [15:0] speed_ref_display_param_i, bus_voltage_display_param_i;
  logic [15:0] temperature_display_param_i;
  integer      seed;                           // Fixed seed keeps runs repeatable
  int          num_errors = 0;
  int          cmp_count = 0;
  logic        got, exc;
  logic [15:0] rdata, tmp, sp;
  logic [15:0] regs [7] = '{REG_OUT_FREQ, REG_OUT_CURRENT, REG_ANALOG_ONE, REG_ANALOG_TWO,
                            REG_SPEED_REF, REG_BUS_VOLTAGE, REG_HEATSINK};
  logic [15:0] pnums [4] = '{16'h0004, 16'h000F, 16'h003C, 16'h0021};

  always #50 clk_i = ~clk_i;

  drive_fieldbus_register_map i_drive_fieldbus_register_map (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_func_i(req_func_i),
    .req_reg_i(req_reg_i), .req_data_i(req_data_i), .rsp_valid_o(rsp_valid_o),
    .rsp_exc_o(rsp_exc_o), .rsp_data_o(rsp_data_o), .run_enable_o(run_enable_o),
    .decel_sel_o(decel_sel_o), .fault_reset_o(fault_reset_o), .coast_stop_o(coast_stop_o),
    .speed_setpoint_o(speed_setpoint_o), .ramp_time_o(ramp_time_o), .param_wr_o(param_wr_o),
    .param_num_o(param_num_o), .param_data_o(param_data_o), .error_code_i(error_code_i),
    .drive_state_i(drive_state_i), .out_freq_i(out_freq_i), .out_current_i(out_current_i),
    .din_pins_i(din_pins_i),
    .analog_one_display_param_i(analog_one_display_param_i),
    .analog_two_display_param_i(analog_two_display_param_i),
    .speed_ref_display_param_i(speed_ref_display_param_i),
    .bus_voltage_display_param_i(bus_voltage_display_param_i),
    .temperature_display_param_i(temperature_display_param_i));

  fieldbus_master i_fieldbus_master (
    .clk_i(clk_i), .req_valid_o(req_valid_i), .req_func_o(req_func_i),
    .req_reg_o(req_reg_i), .req_data_o(req_data_i), .rsp_valid_i(rsp_valid_o),
    .rsp_exc_i(rsp_exc_o), .rsp_data_i(rsp_data_o));

  // Status word as the bank must build it from the live state
  function automatic logic [15:0] stat_exp(input logic [7:0] e, input logic [1:0] s);
    return {6'h00, s, e};
  endfunction

  // Value that a read of a live register must return
  function automatic logic [15:0] live_exp(input logic [15:0] r);
    case (r)
      REG_OUT_FREQ:    return out_freq_i;
      REG_OUT_CURRENT: return out_current_i;
      REG_ANALOG_ONE:  return analog_one_display_param_i;
      REG_ANALOG_TWO:  return analog_two_display_param_i;
      REG_SPEED_REF:   return speed_ref_display_param_i;
      REG_BUS_VOLTAGE: return bus_voltage_display_param_i;
      default:         return temperature_display_param_i;
    endcase
  endfunction

  // One access with its answer compared
  task automatic acc(input logic [7:0] f, input logic [15:0] r, input logic [15:0] d,
                     input logic ee, input logic [15:0] ed);
    i_fieldbus_master.xfer(f, r, d, got, exc, rdata);
    `CHK("answer valid", 1'b1, got)
    `CHK("answer exception", ee, exc)
    `CHK("answer data", ed, rdata)
  endtask

  // Verdict and end of run, reached from the main sequence or the watchdog
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: a hung run counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("mismatch watchdog expected finish seen hang");
    stop_test();
  end

  // Main sequence
  initial begin
    seed = 95546;
    rst_n_i = 1'b0;
    {error_code_i, drive_state_i, din_pins_i} = 14'h0000;
    {out_freq_i, out_current_i, analog_one_display_param_i} = 48'h0;
    {analog_two_display_param_i, speed_ref_display_param_i} = 32'h0;
    {bus_voltage_display_param_i, temperature_display_param_i} = 32'h0;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK("reset commands", 4'h0, {run_enable_o, decel_sel_o, fault_reset_o, coast_stop_o})
    `CHK("reset strobes", 2'h0, {param_wr_o, rsp_valid_o})
    `CHK("reset setpoint", 16'h0000, speed_setpoint_o)
    acc(FUNC_READ, REG_RAMP, 16'h0000, 1'b0, 16'h0000);
    acc(FUNC_READ, 16'h0084, 16'h0000, 1'b0, 16'h0000);
    $display("test reset done");
    // Every control code, with junk in the upper bits
    for (int v = 0; v < 16; v++) begin
      tmp = 16'($random(seed));
      tmp[3:0] = v[3:0];
      acc(FUNC_WRITE_ONE, REG_CONTROL, tmp, 1'b0, tmp);
      `CHK("run enable", v[0], run_enable_o)
      `CHK("decel select", v[1], decel_sel_o)
      `CHK("fault reset pulse", v[2], fault_reset_o)
      `CHK("coast stop", v[3], coast_stop_o)
      @(negedge clk_i);
      `CHK("fault reset end", 1'b0, fault_reset_o)
      acc(FUNC_READ, REG_CONTROL, 16'h0000, 1'b0, {12'h000, v[3:0]});
    end
    $display("test control done");
    // Setpoint and ramp through single and multiple writes
    for (int i = 0; i < 8; i++) begin
      sp = (i == 0) ? 16'h0064 : 16'($random(seed));
      tmp = (i == 0) ? 16'h00FA : 16'($random(seed));
      acc(i[0] ? FUNC_WRITE_MANY : FUNC_WRITE_ONE, REG_SETPOINT, sp, 1'b0, sp);
      `CHK("setpoint out", sp, speed_setpoint_o)
      acc(i[1] ? FUNC_WRITE_MANY : FUNC_WRITE_ONE, REG_RAMP, tmp, 1'b0, tmp);
      `CHK("ramp out", tmp, ramp_time_o)
      acc(FUNC_READ, REG_SETPOINT, 16'h0000, 1'b0, sp);
    end
    $display("test setpoint done");
    // Live registers: every drive state code and random measurements
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_i);
      error_code_i = 8'($random(seed));
      drive_state_i = s[1:0];
      {out_freq_i, out_current_i, analog_one_display_param_i} = {$random(seed),16'($random(seed))};
      {analog_two_display_param_i, speed_ref_display_param_i} = $random(seed);
      {bus_voltage_display_param_i, temperature_display_param_i} = $random(seed);
      acc(FUNC_READ, REG_STATUS, 16'h0000, 1'b0, stat_exp(error_code_i, drive_state_i));
      foreach (regs[k]) acc(FUNC_READ, regs[k], 16'h0000, 1'b0, live_exp(regs[k]));
    end
    // Digital inputs, one pin at a time then a random mix
    for (int k = 0; k < 5; k++) begin
      @(negedge clk_i);
      din_pins_i = (k < 4) ? 4'(1 << k) : 4'($random(seed));
      repeat (4) @(negedge clk_i);
      acc(FUNC_READ, REG_INPUT_PINS, 16'h0000, 1'b0, {12'h000, din_pins_i});
    end
    $display("test live done");
    // Parameters at both ends of the window and inside it
    foreach (pnums[k]) begin
      tmp = 16'($random(seed));
      acc(FUNC_WRITE_ONE, PARAM_BASE + pnums[k], tmp, 1'b0, tmp);
      `CHK("param strobe", 1'b1, param_wr_o)
      `CHK("param number", pnums[k][5:0], param_num_o)
      `CHK("param data", tmp, param_data_o)
      acc(FUNC_READ, PARAM_BASE + pnums[k], 16'h0000, 1'b0, tmp);
    end
    $display("test params done");
    // Refused accesses leave the setpoint and the last written parameter alone
    acc(8'h05, REG_SETPOINT, 16'h1234, 1'b1, {8'h00, EXC_FUNC});
    acc(FUNC_WRITE_ONE, REG_OUT_FREQ, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_WRITE_MANY, REG_STATUS, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_WRITE_MANY, 16'h0003, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_READ, 16'h0003, 16'h0000, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_WRITE_ONE, 16'h0083, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_WRITE_ONE, 16'h00BD, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    acc(FUNC_WRITE_MANY, 16'h00A1, 16'h1234, 1'b1, {8'h00, EXC_ADDR});
    `CHK("param strobe idle", 1'b0, param_wr_o)
    acc(FUNC_READ, REG_SETPOINT, 16'h0000, 1'b0, sp);
    acc(FUNC_READ, 16'h00A1, 16'h0000, 1'b0, tmp);
    $display("test refusals done");
    // Reset in mid-run clears the stores and the parameter words
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    `CHK("rerun setpoint", SETPOINT_RESET, speed_setpoint_o)
    `CHK("rerun ramp", RAMP_RESET, ramp_time_o)
    `CHK("rerun run enable", 1'b0, run_enable_o)
    acc(FUNC_READ, 16'h00A1, 16'h0000, 1'b0, PARAM_RESET);
    $display("test rerun done");
    stop_test();
  end
endmodule
